// File: logic/burst_sram_consts.vh
// Constants for the synchronous burst SRAM port.
// Assumes inclusion by bare name from the logic folder.
`ifndef BURST_SRAM_CONSTS_VH
`define BURST_SRAM_CONSTS_VH
`define ADDR_W 19
`define LANES 4
`define LANE_W 9
`define DATA_W 36
`define BURST_W 2
`define MEM_DEPTH 16
`define MEM_IDX_W 4
`define SLEEP_CYCLES 2
`define ZERO_LANES 4'h0
`define ONES_LANES 4'hF
`define ZERO_DATA 36'h0
`define ZERO_ADDR 19'h0
`define ZERO_BURST 2'h0
`define ONE_BURST 2'h1
`define STATE_W 3
`define STATE_IDLE 3'h1
`define STATE_BURST 3'h2
`define STATE_SLEEP 3'h4
`endif

// File: logic/burst_counter.v
// Two-bit wraparound burst counter, interleaved or linear order.
// Assumes a single clock and active-low asynchronous reset.
`include "burst_sram_consts.vh"
module burst_counter (
    // Clock and reset.
    input wire core_clk,
    input wire rstn,
    input wire clkEn,
    // Control.
    input wire load,
    input wire [`BURST_W-1:0] seed,
    input wire advance,
    input wire linearOrder,
    // Result.
    output wire [`BURST_W-1:0] burstAddr
);
    reg [`BURST_W-1:0] seed_q;
    reg [`BURST_W-1:0] count_q;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seed_q <= `ZERO_BURST;
            count_q <= `ZERO_BURST;
        end else if (clkEn) begin
            if (load) begin
                seed_q <= seed;
                count_q <= `ZERO_BURST;
            end else if (advance) begin
                count_q <= count_q + `ONE_BURST;
            end
        end
    end

    // The address already counts the step of this cycle, so a continue
    // cycle touches the next burst address and a suspend the current one.
    wire [`BURST_W-1:0] step = advance ? `ONE_BURST : `ZERO_BURST;
    wire [`BURST_W-1:0] count = count_q + step;

    // Interleaved order XORs the seed with the count; linear order is an add.
    assign burstAddr = linearOrder ? (seed_q + count) : (seed_q ^ count);
endmodule // burst_counter

// File: logic/sync_burst_sram_port.v
// Synchronous pipelined burst SRAM port with byte-lane writes.
// Assumes all control inputs are synchronous to core_clk; the output
// enable is registered with the read into the data-pin enable.
// What this block does
// - Continue read: strobes idle, advance low, no write reads next address.
// - Continue write: advance low with write steps counter and writes.
// - Suspend read: advance high holds counter and rereads current address.
// - Suspend write: advance high with write writes current address.
// - With byte write enabled and global write high, only lanes with low enables are written.
// - Both write controls high reads; global write low writes all lanes.
// - Write is global write, or byte write with any lane enabled.
// - Advance low steps two-bit counter seeded from low address bits.
// - A processor-strobe cycle with chip_en1_n low is always a read.
// - Output enable is masked in writes; deselect tri-states the pins.
`include "burst_sram_consts.vh"
module sync_burst_sram_port (
    // Clock, reset, enable.
    input wire core_clk,
    input wire rstn,
    input wire clkEn,
    // Burst control.
    input wire proc_addr_strobe_n,
    input wire ctrl_addr_strobe_n,
    input wire burst_advance_n,
    input wire burst_linear,
    input wire chip_en1_n,
    input wire chip_en2,
    input wire chip_en3_n,
    input wire sleep_req,
    // Write control.
    input wire global_write_n,
    input wire byte_write_en_n,
    input wire [`LANES-1:0] lane_write_en_n,
    input wire output_en_n,
    // Address and data.
    input wire [`ADDR_W-1:0] addr,
    input wire [`DATA_W-1:0] dataIn,
    output reg [`DATA_W-1:0] dataOut,
    output reg [`LANES-1:0] dataOutEn
);
    // Access states, one-hot.
    localparam [`STATE_W-1:0] ST_IDLE = `STATE_IDLE;
    localparam [`STATE_W-1:0] ST_BURST = `STATE_BURST;
    localparam [`STATE_W-1:0] ST_SLEEP = `STATE_SLEEP;

    // State of the port.
    reg [`STATE_W-1:0] state_q;
    reg [`STATE_W-1:0] state_d;

    // Upper address bits of the running burst.
    reg [`ADDR_W-1:0] base_q;

    // Sleep request pipeline; entry and exit each take its full length.
    reg [`SLEEP_CYCLES-1:0] sleep_q;

    // Low address bits produced by the burst counter.
    wire [`BURST_W-1:0] burstAddr;

    // Sleep is in force once the request has crossed the whole pipeline.
    wire sleeping;
    assign sleeping = sleep_q[`SLEEP_CYCLES-1];

    // A burst may continue only after a selected start.
    wire active;
    assign active = (state_q == ST_BURST);

    // All three chip enables must agree for a start to select the port.
    wire selected;
    assign selected = !chip_en1_n && chip_en2 && !chip_en3_n;

    // The processor strobe is ignored while the first enable is high.
    wire procStart;
    assign procStart = !proc_addr_strobe_n && !chip_en1_n;

    wire ctrlStart;
    assign ctrlStart = !ctrl_addr_strobe_n;

    wire startCyc;
    assign startCyc = procStart || ctrlStart;

    wire contCyc;
    assign contCyc = !startCyc && active;

    wire writeReq;
    assign writeReq = !global_write_n ||
        (!byte_write_en_n && (lane_write_en_n != `ONES_LANES));

    wire isWrite;
    assign isWrite = writeReq && !procStart;

    wire advance;
    assign advance = contCyc && !burst_advance_n;

    // Address of a continue or suspend cycle; the counter has already
    // folded this cycle's step into its low bits.
    wire [`ADDR_W-1:0] curAddr;
    assign curAddr = {base_q[`ADDR_W-1:`BURST_W], burstAddr};

    // Storage index: a start uses the pins, any other cycle the burst.
    wire [`MEM_IDX_W-1:0] idx;
    assign idx = startCyc ? addr[`MEM_IDX_W-1:0] :
        curAddr[`MEM_IDX_W-1:0];

    // An access happens on a selected start or inside a running burst.
    wire doAccess;
    assign doAccess = !sleeping && (contCyc || (startCyc && selected));

    wire readAcc;
    assign readAcc = doAccess && !isWrite;

    wire writeAcc;
    assign writeAcc = doAccess && isWrite;

    burst_counter counter (
        .core_clk(core_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .load(startCyc && !sleeping),
        .seed(addr[`BURST_W-1:0]),
        .advance(advance && !sleeping),
        .linearOrder(burst_linear),
        .burstAddr(burstAddr)
    );

    // Next state. Sleep drops any burst; after waking the port waits for
    // a fresh start, since a pending access is not kept across sleep.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (sleeping)
                    state_d = ST_SLEEP;
                else if (startCyc && selected)
                    state_d = ST_BURST;
            end
            ST_BURST: begin
                if (sleeping)
                    state_d = ST_SLEEP;
                else if (startCyc && !selected)
                    state_d = ST_IDLE;
            end
            ST_SLEEP: begin
                if (!sleeping)
                    state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            base_q <= `ZERO_ADDR;
            sleep_q <= {`SLEEP_CYCLES{1'b0}};
        end else if (clkEn) begin
            state_q <= state_d;
            sleep_q <= {sleep_q[`SLEEP_CYCLES-2:0], sleep_req};
            if (!sleeping && startCyc)
                base_q <= addr;
        end
    end

    // Each lane keeps its own storage, so a byte write never touches
    // the bytes beside it.
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : lane
            reg [`LANE_W-1:0] laneMem [0:`MEM_DEPTH-1];

            wire laneSel;
            assign laneSel = !global_write_n ||
                (!byte_write_en_n && !lane_write_en_n[g]);

            always @(posedge core_clk) begin
                if (clkEn && writeAcc && laneSel)
                    laneMem[idx] <= dataIn[g*`LANE_W +: `LANE_W];
            end

            always @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    dataOut[g*`LANE_W +: `LANE_W] <= {`LANE_W{1'b0}};
                    dataOutEn[g] <= 1'b0;
                end else if (clkEn) begin
                    if (readAcc)
                        dataOut[g*`LANE_W +: `LANE_W] <= laneMem[idx];
                    dataOutEn[g] <= readAcc && !output_en_n;
                end
            end
        end
    endgenerate
endmodule // sync_burst_sram_port

// File: dv/sram_port_props.sv
// Pin checker for the burst SRAM port.
// Assumes clkEn high, sleep_req low, chip_en1_n and chip_en3_n low.
module sram_port_props (input logic core_clk, rstn, chip_en2, output_en_n,
    proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n,
    byte_write_en_n, input logic [3:0] lane_write_en_n, dataOutEn);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire wr = !global_write_n || !byte_write_en_n && lane_write_en_n != 4'hF;
    wire mid = proc_addr_strobe_n && ctrl_addr_strobe_n;
    wire go = chip_en2 && !ctrl_addr_strobe_n && proc_addr_strobe_n;
    sequence rd; dataOutEn == 4'hF; endsequence
    AST_WR: assert property (go && wr |=> !dataOutEn)
        else $error("write drove");
    AST_RD: assert property (go && !wr && !output_en_n |=> rd)
        else $error("read idle");
    AST_PRD: assert property (chip_en2 && !proc_addr_strobe_n
        && !output_en_n |=> rd) else $error("strobe read idle");
    AST_OE: assert property (|dataOutEn |-> !$past(output_en_n))
        else $error("enable ignored");
    AST_DSL: assert property (!chip_en2 && !ctrl_addr_strobe_n
        |-> ##[1:2] !dataOutEn) else $error("deselect drove");
    AST_CWR: assert property (mid && !burst_advance_n && wr
        |=> !dataOutEn) else $error("burst write drove");
    AST_SWR: assert property (mid && burst_advance_n && wr
        |=> !dataOutEn) else $error("suspend write drove");
    AST_HLD: assert property (rd ##0 (mid && !wr && !output_en_n)
        |=> rd) else $error("burst read idle");
endmodule // sram_port_props
bind sync_burst_sram_port sram_port_props chk (.*);

// File: dv/burst_master.sv
// Controller model: one bus cycle per call, applied at the falling edge.
// Assumes controls packed as {chip_en2, strobes, advance, writes, oe}.
module burst_master (input logic core_clk,
    output logic chip_en2 = 1'h0, proc_addr_strobe_n = 1'h1,
    ctrl_addr_strobe_n = 1'h1, burst_advance_n = 1'h1,
    global_write_n = 1'h1, byte_write_en_n = 1'h1, output_en_n = 1'h1,
    output logic [3:0] lane_write_en_n = 4'hF,
    output logic [18:0] addr = 19'h0,
    output logic [35:0] dataIn = 36'h0);
    task cyc(logic [10:0] c, logic [18:0] a, logic [35:0] d);
        @(negedge core_clk);
        {chip_en2, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
            global_write_n, byte_write_en_n, lane_write_en_n} <= c[10:1];
        output_en_n <= c[0];
        addr <= a;
        dataIn <= d;
    endtask
endmodule // burst_master

// File: dv/tb.sv
// Bench for the burst SRAM port with a read scoreboard.
// Assumes burst_master applies one bus cycle per call.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rstn = 0, burst_linear = 0;
    logic [35:0] mem [16], q [$], dataOut, d, w;
    logic [3:0] dataOutEn, cur, ix;
    logic [1:0] n;
    logic wr;
    logic [15:0] r = 16'hB8C6;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    wire chip_en2, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
    wire global_write_n, byte_write_en_n, output_en_n;
    wire [3:0] lane_write_en_n;
    wire [18:0] addr;
    wire [35:0] dataIn;
    burst_master m (.*);
    sync_burst_sram_port dut (.*, .clkEn(1'h1), .sleep_req(1'h0),
        .chip_en1_n(1'h0), .chip_en3_n(1'h0));
    initial forever #20 core_clk = !core_clk;
    function logic [15:0] nx(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task chk(logic [39:0] g, x);
        num_checks++;
        n_mismatch += g !== x;
        if (g !== x) $display("MISMATCH %0t read %h", $time, g);
    endtask
    task stop_test;
        n_mismatch += cyc > 400;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task op(logic [10:0] c, logic [3:0] a);
        r = nx(r);
        d = {r, r[3:0], r};
        m.cyc(c, {15'h0, a}, d);
        if (!c[8] || !c[9]) {cur, n} = {a, 2'h0};
        else if (!c[7]) n++;
        ix = {cur[3:2], burst_linear ? cur[1:0] + n : cur[1:0] ^ n};
        w = mem[ix];
        wr = c[9] && (!c[6] || !c[5] && c[4:1] != 4'hF);
        for (int i = 0; i < 4; i++)
            if (wr && (!c[6] || !c[i + 1])) w[9*i +: 9] = d[9*i +: 9];
        if (wr) mem[ix] = w;
        else if (!c[0] && c[10]) q.push_back(w);
    endtask
    always @(posedge core_clk) begin
        if (++cyc > 400) stop_test;
        #1;
        if (dataOutEn !== 4'h0)
            chk({dataOutEn, dataOut}, {4'hF, q.pop_front()});
    end
    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1;
        for (int k = 0; k < 16; k++) begin
            op(11'h6BF, k[3:0]);
            op({6'h36, k[3:0], 1'h1}, k[3:0]);
            op(11'h6DE, k[3:0]);
        end
        $display("lanes done");
        for (int k = 0; k < 8; k++) begin
            burst_linear = k[2];
            op(k[0] ? 11'h6FE : 11'h580, k[3:0]);
            repeat (3) op(11'h77E, 4'h0);
            op(11'h7FE, 4'h0);
            op(11'h7FF, 4'h0);
        end
        $display("reads done");
        op(11'h6BF, 4'h8);
        op(11'h73F, 4'h0);
        op(11'h7BF, 4'h0);
        op(11'h6FE, 4'h9);
        op(11'h7FF, 4'h0);
        op(11'h2FE, 4'h0);
        repeat (2) op(11'h7FF, 4'h0);
        $display("writes done");
        stop_test;
    end
endmodule // tb
